// file: frame_pop_map.vh
`ifndef FRAME_POP_MAP_VH
`define FRAME_POP_MAP_VH
// ----------------------------------------
// operation codes
// ----------------------------------------
`define OP_RESTORE          2'h0
`define OP_RESTORE_RET      2'h1
`define OP_RESTORE_RET_ZERO 2'h2
// ----------------------------------------
// variants
// ----------------------------------------
`define VAR_RV32E 2'h0
`define VAR_RV32I 2'h1
`define VAR_RV64  2'h2
// ----------------------------------------
// field layout and constants
// ----------------------------------------
`define LIST_MIN       4'h4
`define LIST_FULL      4'hF
`define SPIMM_HI       5
`define SPIMM_LO       4
`define FRAME_UNIT     8'h10
`define REG_RA         5'h01
`define REG_SP         5'h02
`define REG_A0         5'h0A
`define WORD_BYTES     4'h4
`define DWORD_BYTES    4'h8
`define CAUSE_ILLEGAL  5'h02
`define CAUSE_LOAD_FAULT 5'h05
`endif

// file: frame_size_calc.v
`timescale 1ns/1ns
`include "frame_pop_map.vh"
// frame size in bytes for the configured variant
module frame_size_calc
(
	input  wire [1:0] variant,
	input  wire [3:0] rlist,
	input  wire [1:0] spimm,
	output reg  [7:0] frame
);
	reg [7:0] base;
	always @*
	begin
		base = 8'h10;
		case (variant)
			`VAR_RV32E: base = 8'h10;
			`VAR_RV32I:
			begin
				if (rlist == 4'hF)      base = 8'h40;
				else if (rlist >= 4'hC) base = 8'h30;
				else if (rlist >= 4'h8) base = 8'h20;
				else                    base = 8'h10;
			end
			default:
			begin
				if (rlist == 4'hF)      base = 8'h70;
				else if (rlist == 4'hE) base = 8'h60;
				else                    base = {1'b0, rlist[3:1] - 3'h1, 4'h0};
			end
		endcase
		frame = base + {2'h0, spimm, 4'h0};
	end
endmodule // frame_size_calc

// file: mem_model.sv
`timescale 1ns/1ns
module mem_model
(
	input wire          ref_clk,
	input wire          ld_req_r,
	input wire [31:0]   ld_addr_r,
	input wire          slow,
	input wire          flt,
	output logic        ld_done = 1'b0,
	output logic        ld_fault = 1'b0,
	output logic [31:0] ld_data = 32'h0
);
logic [1:0]  n = 2'h0;
logic        p = 1'b0;
logic [31:0] a;
// idle data scrambled so a stale value never passes
always @(posedge ref_clk)
begin
	ld_done <= 1'b0;
	ld_fault <= 1'b0;
	ld_data <= ~ld_data;
	if (ld_req_r)
	begin
		p <= 1'b1;
		a <= ld_addr_r;
		n <= slow ? 2'h3 : 2'h0;
	end
	else if (p && n != 2'h0)
		n <= n - 2'h1;
	else if (p)
	begin
		p <= 1'b0;
		ld_fault <= flt;
		ld_done <= !flt;
		ld_data <= {a[15:0], ~a[15:0]};
	end
end
endmodule // mem_model

// file: pop_list_decode.v
`timescale 1ns/1ns
`include "frame_pop_map.vh"
// maps a load index (0 = first load) to its destination register
module pop_list_decode
(
	input  wire [3:0] rlist,
	input  wire [3:0] idx,
	output reg  [4:0] dest,
	output reg  [3:0] count
);
	reg [3:0] sregs;
	always @*
	begin
		sregs = 4'h0;
		dest  = `REG_RA;
		// list 15 jumps from 10 saved regs to 12, so s10 never stands alone
		if (rlist == `LIST_FULL)
			sregs = 4'hC;
		else if (rlist >= `LIST_MIN)
			sregs = rlist - `LIST_MIN;
		count = sregs + 4'h1;
		// order: x27..x18, then x9, x8, x1
		if (idx >= sregs)
			dest = `REG_RA;
		else if (sregs - idx <= 4'h2)
			dest = 5'h08 + {1'b0, sregs - idx - 4'h1};
		else
			dest = 5'h12 + {1'b0, sregs - idx - 4'h3};
	end
endmodule // pop_list_decode

// file: stack_frame_pop_sequencer.v
`timescale 1ns/1ns
`include "frame_pop_map.vh"
// ----------------------------------------
// ----------------------------------------
module stack_frame_pop_sequencer
#(
	parameter       NATIVE_REGISTER_WIDTH = 32,
	parameter [1:0] VARIANT               = `VAR_RV32I
)
(
	input  wire                             ref_clk,
	input  wire                             rst,
	input  wire                             start,
	input  wire [1:0]                       op,
	input  wire [3:0]                       rlist,
	input  wire [5:0]                       spimm,
	input  wire [NATIVE_REGISTER_WIDTH-1:0] sp_val,
	input  wire [NATIVE_REGISTER_WIDTH-1:0] ra_val,
	input  wire [NATIVE_REGISTER_WIDTH-1:0] inst_pc,
	input  wire                             abort,
	output reg                              ld_req_r,
	output reg  [NATIVE_REGISTER_WIDTH-1:0] ld_addr_r,
	output reg  [3:0]                       ld_size_r,
	input  wire                             ld_done,
	input  wire                             ld_fault,
	input  wire [NATIVE_REGISTER_WIDTH-1:0] ld_data,
	output reg                              rf_we_r,
	output reg  [4:0]                       rf_waddr_r,
	output reg  [NATIVE_REGISTER_WIDTH-1:0] rf_wdata_r,
	output reg                              commit_r,
	output reg                              sp_we_r,
	output reg  [NATIVE_REGISTER_WIDTH-1:0] sp_new_r,
	output reg                              a0_zero_r,
	output reg                              jump_r,
	output reg  [NATIVE_REGISTER_WIDTH-1:0] jump_target_r,
	output reg                              trap_r,
	output reg  [4:0]                       trap_cause_r,
	output reg  [NATIVE_REGISTER_WIDTH-1:0] trap_pc_r,
	output reg                              busy_r
);
	// ----------------------------------------
	// constants and states
	// ----------------------------------------
	localparam integer W = NATIVE_REGISTER_WIDTH;

	localparam [3:0] S_IDLE  = 4'h1;
	localparam [3:0] S_LOAD  = 4'h2;
	localparam [3:0] S_WAIT  = 4'h4;
	localparam [3:0] S_CLOSE = 4'h8;

	localparam [3:0] STEP = (W == 32) ? `WORD_BYTES : `DWORD_BYTES;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	// list values 0-3 belong to another calling convention
	function is_reserved;
		input [3:0] r;
		begin
			is_reserved = (r < `LIST_MIN);
		end
	endfunction

	reg  [3:0]   state_r;
	reg  [3:0]   idx_r;
	reg  [3:0]   list_r;
	reg  [1:0]   op_r;
	reg  [1:0]   spimm_r;
	reg  [W-1:0] sp_r;
	reg  [W-1:0] ra_new_r;
	reg  [W-1:0] addr_r;
	wire [4:0]   dest;
	wire [3:0]   count;
	wire [7:0]   frame;
	wire [7:0]   frame_in;
	wire [W-1:0] step_w;
	wire [W-1:0] frame_w;
	wire [W-1:0] frame_in_w;
	wire         in_idle;
	wire         in_load;
	wire         in_wait;
	wire         in_close;
	wire         accept;
	wire         reject;
	wire         issue;
	wire         load_ok;
	wire         load_bad;
	wire         close_go;
	wire         last_load;

	assign step_w     = {{(W-4){1'b0}}, STEP};
	assign frame_w    = {{(W-8){1'b0}}, frame};
	assign frame_in_w = {{(W-8){1'b0}}, frame_in};

	assign in_idle  = (state_r == S_IDLE);
	assign in_load  = (state_r == S_LOAD);
	assign in_wait  = (state_r == S_WAIT);
	assign in_close = (state_r == S_CLOSE);

	// start is only taken in idle, so a start while busy is dropped
	assign accept    = in_idle && start && !is_reserved(rlist);
	assign reject    = in_idle && start && is_reserved(rlist);
	assign issue     = in_load && !abort;
	assign load_ok   = in_wait && !ld_fault && !abort && ld_done;
	assign load_bad  = in_wait && (ld_fault || abort);
	assign close_go  = in_close && !abort;
	assign last_load = ((idx_r + 4'h1) == count);

	pop_list_decode u_dec
	(
		.rlist (list_r),
		.idx   (idx_r),
		.dest  (dest),
		.count (count)
	);

	frame_size_calc u_frame
	(
		.variant (VARIANT),
		.rlist   (list_r),
		.spimm   (spimm_r),
		.frame   (frame)
	);

	frame_size_calc u_frame_in
	(
		.variant (VARIANT),
		.rlist   (rlist),
		.spimm   (spimm[`SPIMM_HI:`SPIMM_LO]),
		.frame   (frame_in)
	);

	// ----------------------------------------
	// sequencer state
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_r <= S_IDLE;
			idx_r   <= 4'h0;
			list_r  <= 4'h0;
			op_r    <= 2'h0;
			spimm_r <= 2'h0;
			sp_r    <= {W{1'b0}};
			addr_r  <= {W{1'b0}};
			busy_r  <= 1'b0;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (accept)
					begin
						list_r  <= rlist;
						op_r    <= op;
						spimm_r <= spimm[`SPIMM_HI:`SPIMM_LO];
						sp_r    <= sp_val;
						idx_r   <= 4'h0;
						// first address: sp + frame - one step
						addr_r  <= sp_val + frame_in_w - step_w;
						busy_r  <= 1'b1;
						state_r <= S_LOAD;
					end
				end
				S_LOAD:
				begin
					if (abort)
					begin
						// sp untouched, so a re-issue restarts cleanly
						busy_r  <= 1'b0;
						state_r <= S_IDLE;
					end
					else
					begin
						state_r <= S_WAIT;
					end
				end
				S_WAIT:
				begin
					if (ld_fault || abort)
					begin
						// loaded registers may be clobbered; re-run rewrites them
						busy_r  <= 1'b0;
						state_r <= S_IDLE;
					end
					else if (ld_done)
					begin
						addr_r <= addr_r - step_w;
						idx_r  <= idx_r + 4'h1;
						if (last_load)
						begin
							state_r <= S_CLOSE;
						end
						else
						begin
							state_r <= S_LOAD;
						end
					end
				end
				S_CLOSE:
				begin
					// an abort here still leaves sp and the pc untouched
					busy_r  <= 1'b0;
					state_r <= S_IDLE;
				end
				default:
				begin
					busy_r  <= 1'b0;
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// load port
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			ld_req_r  <= 1'b0;
			ld_addr_r <= {W{1'b0}};
			ld_size_r <= 4'h0;
		end
		else
		begin
			ld_req_r <= issue;
			if (issue)
			begin
				ld_addr_r <= addr_r;
				ld_size_r <= STEP;
			end
		end
	end

	// ----------------------------------------
	// register write-back
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			rf_we_r    <= 1'b0;
			rf_waddr_r <= 5'h00;
			rf_wdata_r <= {W{1'b0}};
			ra_new_r   <= {W{1'b0}};
		end
		else
		begin
			rf_we_r <= load_ok;
			if (accept)
			begin
				ra_new_r <= ra_val;
			end
			if (load_ok)
			begin
				rf_waddr_r <= dest;
				rf_wdata_r <= ld_data;
				// the jump must use the restored ra, not the one at start
				if (dest == `REG_RA)
				begin
					ra_new_r <= ld_data;
				end
			end
		end
	end

	// ----------------------------------------
	// closing step
	// ----------------------------------------
	// all outputs of the closing step rise in one cycle
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			commit_r      <= 1'b0;
			sp_we_r       <= 1'b0;
			sp_new_r      <= {W{1'b0}};
			a0_zero_r     <= 1'b0;
			jump_r        <= 1'b0;
			jump_target_r <= {W{1'b0}};
		end
		else
		begin
			commit_r  <= close_go;
			sp_we_r   <= close_go;
			a0_zero_r <= close_go && (op_r == `OP_RESTORE_RET_ZERO);
			jump_r    <= close_go && (op_r != `OP_RESTORE);
			if (close_go)
			begin
				sp_new_r      <= sp_r + frame_w;
				jump_target_r <= ra_new_r;
			end
		end
	end

	// ----------------------------------------
	// traps
	// ----------------------------------------
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			trap_r       <= 1'b0;
			trap_cause_r <= 5'h00;
			trap_pc_r    <= {W{1'b0}};
		end
		else
		begin
			// no load issued and sp never written on a reserved list
			trap_r <= reject || (in_wait && ld_fault);
			if (reject)
			begin
				trap_cause_r <= `CAUSE_ILLEGAL;
			end
			else if (load_bad)
			begin
				trap_cause_r <= `CAUSE_LOAD_FAULT;
			end
			if (accept || reject)
			begin
				trap_pc_r <= inst_pc;
			end
		end
	end
endmodule // stack_frame_pop_sequencer

// file: stack_frame_pop_sequencer_chk.sv
`timescale 1ns/1ns
module pop_seq_chk
(
	input wire       ref_clk,
	input wire       rst,
	input wire       start,
	input wire       busy_r,
	input wire [3:0] rlist,
	input wire [1:0] op,
	input wire       abort,
	input wire       ld_req_r,
	input wire       ld_done,
	input wire       ld_fault,
	input wire       rf_we_r,
	input wire       commit_r,
	input wire       sp_we_r,
	input wire       jump_r,
	input wire       a0_zero_r,
	input wire       trap_r
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
// op may change once taken, so compare against the one latched at start
logic [1:0] op_seen;
always @(posedge ref_clk)
	if (start && !busy_r)
		op_seen <= op;
property p_rsv; start && !busy_r && rlist < 4 |=> trap_r && !ld_req_r ##1 !ld_req_r; endproperty
a_rsv: assert property (p_rsv) else $error("reserved list not trapped");
property p_go; start && !busy_r && rlist >= 4 ##1 !abort |-> busy_r && !trap_r ##1 ld_req_r;
endproperty
a_go: assert property (p_go) else $error("first load late");
property p_wb; ld_done && busy_r && !abort |=> rf_we_r; endproperty
a_wb: assert property (p_wb) else $error("load not written");
property p_sp; commit_r |-> sp_we_r && !busy_r && !trap_r; endproperty
a_sp: assert property (p_sp) else $error("closing step split");
property p_jump; commit_r |-> jump_r == (op_seen != 2'h0); endproperty
a_jump: assert property (p_jump) else $error("jump wrong");
property p_a0; commit_r |-> a0_zero_r == (op_seen == 2'h2); endproperty
a_a0: assert property (p_a0) else $error("a0 clear wrong");
property p_flt; ld_fault && busy_r |=> !commit_r [*4]; endproperty
a_flt: assert property (p_flt) else $error("commit after fault");
property p_abt; abort && busy_r |=> !commit_r && !trap_r; endproperty
a_abt: assert property (p_abt) else $error("abort not silent");
endmodule // pop_seq_chk
bind stack_frame_pop_sequencer pop_seq_chk u_pop_seq_chk (.*);

// file: stack_frame_pop_sequencer_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
	$display("wrong value %s exp %h got %h", n, e, g); end end
module stack_frame_pop_sequencer_tb;
logic        ref_clk = 0, rst = 1, start = 0, abort = 0, slow = 0, flt = 0;
logic [1:0]  op = 0;
logic [3:0]  rlist = 4, ld_size_r;
logic [5:0]  spimm = 0;
logic [31:0] sp_val = 0, ra_val = 0, inst_pc = 0, ld_addr_r, ld_data, rf_wdata_r;
logic [31:0] sp_new_r, jump_target_r, trap_pc_r;
logic        ld_req_r, ld_done, ld_fault, rf_we_r, commit_r, sp_we_r, a0_zero_r, jump_r;
logic        trap_r, busy_r;
logic [4:0]  rf_waddr_r, trap_cause_r;
logic [31:0] e_addr, e_sp, w_addr, w_sp;
int          failures = 0, check_count = 0;
always #5 ref_clk = ~ref_clk;
stack_frame_pop_sequencer #(.NATIVE_REGISTER_WIDTH(32), .VARIANT(2'h1))
	u_stack_frame_pop_sequencer (.*);
// the other two variants run in lock step and are checked on address and sp only
stack_frame_pop_sequencer #(.NATIVE_REGISTER_WIDTH(32), .VARIANT(2'h0))
	u_stack_frame_pop_sequencer_e (.ref_clk(ref_clk), .rst(rst), .start(start), .op(op),
	.rlist(rlist), .spimm(spimm), .sp_val(sp_val), .ra_val(ra_val), .inst_pc(inst_pc),
	.abort(abort), .ld_req_r(), .ld_addr_r(e_addr), .ld_size_r(), .ld_done(ld_done),
	.ld_fault(ld_fault), .ld_data(ld_data), .rf_we_r(), .rf_waddr_r(), .rf_wdata_r(),
	.commit_r(), .sp_we_r(), .sp_new_r(e_sp), .a0_zero_r(), .jump_r(), .jump_target_r(),
	.trap_r(), .trap_cause_r(), .trap_pc_r(), .busy_r());
stack_frame_pop_sequencer #(.NATIVE_REGISTER_WIDTH(32), .VARIANT(2'h2))
	u_stack_frame_pop_sequencer_w (.ref_clk(ref_clk), .rst(rst), .start(start), .op(op),
	.rlist(rlist), .spimm(spimm), .sp_val(sp_val), .ra_val(ra_val), .inst_pc(inst_pc),
	.abort(abort), .ld_req_r(), .ld_addr_r(w_addr), .ld_size_r(), .ld_done(ld_done),
	.ld_fault(ld_fault), .ld_data(ld_data), .rf_we_r(), .rf_waddr_r(), .rf_wdata_r(),
	.commit_r(), .sp_we_r(), .sp_new_r(w_sp), .a0_zero_r(), .jump_r(), .jump_target_r(),
	.trap_r(), .trap_cause_r(), .trap_pc_r(), .busy_r());
mem_model u_mem_model (.*);
function logic [7:0] frame(logic [3:0] r, logic [5:0] i);
	return (r < 8 ? 8'h10 : r < 12 ? 8'h20 : r < 15 ? 8'h30 : 8'h40) + i[5:4] * 8'h10;
endfunction
function logic [7:0] frame_e(logic [5:0] i);
	return 8'h10 + i[5:4] * 8'h10;
endfunction
function logic [7:0] frame_w(logic [3:0] r, logic [5:0] i);
	return (r < 6 ? 8'h10 : r < 8 ? 8'h20 : r < 10 ? 8'h30 : r < 12 ? 8'h40 :
		r < 14 ? 8'h50 : r < 15 ? 8'h60 : 8'h70) + i[5:4] * 8'h10;
endfunction
// j counts back from the last load, which is always ra
function logic [4:0] dst(int j);
	return j == 0 ? 5'h01 : j < 3 ? 5'(j + 7) : 5'(j + 15);
endfunction
function logic [31:0] dat(logic [31:0] a);
	return {a[15:0], ~a[15:0]};
endfunction
task report_and_stop;
	$display("checks %0d failures %0d", check_count, failures);
	if (failures == 0 && check_count > 0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
task run(input [1:0] o, input [3:0] r, input [5:0] i, input int ab, input logic f);
	int n, q, w, c;
	logic [31:0] sp, b;
	sp = $urandom & 32'hFFFFFFF0;
	n = r == 15 ? 13 : r - 3;
	b = sp + frame(r, i) - 4;
	q = 0;
	w = 0;
	@(posedge ref_clk);
	start <= 1;
	op <= o;
	rlist <= r;
	spimm <= i;
	sp_val <= sp;
	ra_val <= $urandom;
	inst_pc <= $urandom;
	flt <= f;
	for (c = 1; c < 300; c++)
	begin
		@(posedge ref_clk);
		start <= 0;
		abort <= c == ab;
		slow <= $urandom;
		#1;
		if (ld_req_r)
		begin
			`CHK("addr", b - 4 * q, ld_addr_r)
			`CHK("addr rv32e", sp + frame_e(i) - 4 - 4 * q, e_addr)
			`CHK("addr rv64", sp + frame_w(r, i) - 4 - 4 * q, w_addr)
			`CHK("size", 4'h4, ld_size_r)
			q++;
		end
		if (rf_we_r)
		begin
			`CHK("dest", dst(n - 1 - w), rf_waddr_r)
			`CHK("data", dat(b - 4 * w), rf_wdata_r)
			w++;
		end
		if (commit_r)
		begin
			`CHK("loads", n, w)
			`CHK("sp", sp + frame(r, i), sp_new_r)
			`CHK("sp rv32e", sp + frame_e(i), e_sp)
			`CHK("sp rv64", sp + frame_w(r, i), w_sp)
			`CHK("sp we", 1'b1, sp_we_r)
			`CHK("jump", o != 0, jump_r)
			`CHK("a0 zero", o == 2, a0_zero_r)
			if (o != 0) `CHK("target", dat(b - 4 * (n - 1)), jump_target_r)
			break;
		end
		if (trap_r)
		begin
			`CHK("cause", r < 4 ? 5'h02 : 5'h05, trap_cause_r)
			`CHK("pc", inst_pc, trap_pc_r)
			break;
		end
		if (ab > 0 && c > ab && !busy_r)
			break;
	end
	`CHK("trapped", r < 4 || f, trap_r)
	`CHK("finished", 1'b1, c < 300)
	abort <= 0;
	// let a load abandoned by abort drain before the next start
	repeat (6) @(posedge ref_clk);
	$display("test op %0d list %0d done", o, r);
endtask
initial
begin
	void'($urandom(32'h2A4C));
	repeat (3) @(posedge ref_clk);
	rst <= 0;
	for (int k = 0; k < 4; k++) run(k % 3, k, 6'h30, 0, 0);
	for (int k = 0; k < 6; k++) run(k % 3, k < 3 ? 4 : 15, 6'h30, 0, 0);
	repeat (30) run($urandom % 3, 4 + $urandom % 12, $urandom, 0, 0);
	run(2, 15, 0, 0, 1);
	run(2, 15, 0, 0, 0);
	run(1, 9, 6'h10, 7, 0);
	run(1, 9, 6'h10, 0, 0);
	report_and_stop;
end
initial
begin
	#400000;
	failures++;
	report_and_stop;
end
endmodule // stack_frame_pop_sequencer_tb
